// ==== bmbr_buf_group.sv ====
`timescale 1ns/1ns

// one tri-state buffer group: disable acts combinationally
module bmbr_buf_group #(
    parameter int W = 8
) (
    // core side
    input wire logic [W-1:0] core_q_i,
    input wire logic core_en_i,
    // bus side
    input wire logic dsb_i,
    output logic [W-1:0] bus_q_o,
    output logic [W-1:0] bus_oe_o
);

    // ------------------------------------------------------------
    // per-bit enable
    // ------------------------------------------------------------
    // no clock here so a release lands in the same bus cycle
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            assign bus_q_o[g] = core_q_i[g];
            assign bus_oe_o[g] = core_en_i & ~dsb_i;
        end
    endgenerate

endmodule

// ==== bmbr_chk_properties.sv ====
`timescale 1ns/1ns
`include "bmbr_defs.svh"

// ----------------------------------------
// buffer release and hold checks
// ----------------------------------------
module bmbr_chk (
    // clock, reset and inputs
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic stat_dsb_i,
    input wire logic cc_dsb_i,
    input wire logic addr_dsb_i,
    input wire logic dout_dsb_i,
    input wire logic hold_req_i,
    input wire logic cycle_end_i,
    // watched outputs
    input wire logic [`BMBR_STAT_W-1:0] stat_oe_o,
    input wire logic [`BMBR_CC_W-1:0] cc_oe_o,
    input wire logic [`BMBR_ADDR_W-1:0] addr_oe_o,
    input wire logic [`BMBR_DATA_W-1:0] dout_oe_o,
    input wire logic hlda_o,
    input wire logic in_hold_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_stat;
        stat_dsb_i |-> stat_oe_o == '0;
    endproperty
    a_stat: assert property (p_stat)
        else $error("status not floated");
    property p_cc;
        cc_dsb_i |-> cc_oe_o == '0;
    endproperty
    a_cc: assert property (p_cc)
        else $error("control not floated");
    property p_addr;
        addr_dsb_i |-> addr_oe_o == '0;
    endproperty
    a_addr: assert property (p_addr)
        else $error("address not floated");
    property p_dout;
        dout_dsb_i |-> dout_oe_o == '0;
    endproperty
    a_dout: assert property (p_dout)
        else $error("data not floated");
    property p_ack;
        hlda_o |-> $past(hold_req_i);
    endproperty
    a_ack: assert property (p_ack)
        else $error("unrequested ack");
    property p_enter;
        $rose(in_hold_o) |-> $past(cycle_end_i) && hlda_o;
    endproperty
    a_enter: assert property (p_enter)
        else $error("early hold");
    property p_float;
        in_hold_o |-> (addr_oe_o | dout_oe_o) == '0;
    endproperty
    a_float: assert property (p_float)
        else $error("bus driven in hold");
    // enables must follow the disable itself, not a later edge
    property p_live;
        $past(rst_n_i, 3) && !stat_dsb_i |-> &stat_oe_o;
    endproperty
    a_live: assert property (p_live)
        else $error("status not driven");
endmodule

bind bmbr_top bmbr_chk u_chk (.ref_clk_i, .rst_n_i, .stat_dsb_i, .cc_dsb_i,
    .addr_dsb_i, .dout_dsb_i, .hold_req_i, .cycle_end_i, .stat_oe_o,
    .cc_oe_o, .addr_oe_o, .dout_oe_o, .hlda_o, .in_hold_o);

// ==== bmbr_defs.svh ====
`ifndef BMBR_DEFS_SVH
`define BMBR_DEFS_SVH

// ----------------------------------------------------------------
// widths of the buffer groups
// ----------------------------------------------------------------
`define BMBR_STAT_W 8
`define BMBR_CC_W 6
`define BMBR_ADDR_W 16
`define BMBR_DATA_W 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BMBR_SYNC_RST 2'h0
`define BMBR_HLDA_RST 1'h0
`define BMBR_HOLD_RST 1'h0
`define BMBR_RDY_RST 1'h0
`define BMBR_STAT_RST 8'h00
`define BMBR_CC_RST 6'h00
`define BMBR_ADDR_RST 16'h0000
`define BMBR_DATA_RST 8'h00

`endif

// ==== bmbr_peer.sv ====
`timescale 1ns/1ns

// ----------------------------------------
// far-side bus master card
// ----------------------------------------
module bmbr_peer (
    // bench commands
    input wire logic ref_clk_i,
    input wire logic want_i,
    input wire logic slow_i,
    // bus lines
    output logic hold_req_o = 1'b0,
    output logic ext_rdy_o = 1'b1
);
    // card registers its requests, one cycle behind the bench
    always_ff @(posedge ref_clk_i) begin
        hold_req_o <= want_i;
        ext_rdy_o <= !slow_i;
    end
endmodule

// ==== bmbr_pkg.sv ====
package bmbr_pkg;

    // hold handover states
    typedef enum logic [1:0] {
        BMBR_RUN = 2'b00,
        BMBR_FINISH = 2'b01,
        BMBR_HOLD = 2'b10
    } bmbr_hold_e;

endpackage

// ==== bmbr_top.sv ====
`timescale 1ns/1ns
`include "bmbr_defs.svh"

module bmbr_top (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // core side values
    input wire logic [`BMBR_STAT_W-1:0] stat_q_i,
    input wire logic [`BMBR_CC_W-1:0] cc_q_i,
    input wire logic [`BMBR_ADDR_W-1:0] addr_q_i,
    input wire logic [`BMBR_DATA_W-1:0] dout_q_i,
    input wire logic dout_en_i,
    input wire logic cycle_end_i,
    // bus control inputs
    input wire logic stat_dsb_i,
    input wire logic cc_dsb_i,
    input wire logic addr_dsb_i,
    input wire logic dout_dsb_i,
    input wire logic hold_req_i,
    input wire logic ext_rdy_i,
    input wire logic unprot_i,
    input wire logic single_step_i,
    // bus outputs
    output logic [`BMBR_STAT_W-1:0] stat_o,
    output logic [`BMBR_STAT_W-1:0] stat_oe_o,
    output logic [`BMBR_CC_W-1:0] cc_o,
    output logic [`BMBR_CC_W-1:0] cc_oe_o,
    output logic [`BMBR_ADDR_W-1:0] addr_o,
    output logic [`BMBR_ADDR_W-1:0] addr_oe_o,
    output logic [`BMBR_DATA_W-1:0] dout_o,
    output logic [`BMBR_DATA_W-1:0] dout_oe_o,
    output logic hlda_o,
    output logic cpu_rdy_o,
    output logic in_hold_o
);

    // ------------------------------------------------------------
    // internal state
    // ------------------------------------------------------------
    // reset copy that the whole block runs on
    logic [1:0] rst_sync_r;
    logic rst_n;
    // hold handover
    bmbr_pkg::bmbr_hold_e st_r;
    bmbr_pkg::bmbr_hold_e st_nxt;
    logic hlda_r;
    logic in_hold_r;
    logic bus_own;
    // ready and core values on their way to the pins
    logic rdy_r;
    logic [`BMBR_STAT_W-1:0] stat_q_r;
    logic [`BMBR_CC_W-1:0] cc_q_r;
    logic [`BMBR_ADDR_W-1:0] addr_q_r;
    logic [`BMBR_DATA_W-1:0] dout_q_r;
    // sink for the two lines the board leaves alone
    logic ignored_unused;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // asserts at once, lets go only on an edge so no flop sees a runt
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_r <= `BMBR_SYNC_RST;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // ignored bus lines
    // ------------------------------------------------------------
    // memory-unprotect and single-step reach no logic; the sink only
    // keeps both pins named so a later card revision can pick them up
    assign ignored_unused = unprot_i | single_step_i;

    // ------------------------------------------------------------
    // hold handover
    // ------------------------------------------------------------
    // finish the running cycle before giving up the bus
    // walk: run, finish while the cycle runs out, hold until released;
    // acknowledge and hold flag drop on the same edge that takes the bus back
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            bmbr_pkg::BMBR_RUN: begin
                if (hold_req_i) begin
                    st_nxt = cycle_end_i ? bmbr_pkg::BMBR_HOLD
                                         : bmbr_pkg::BMBR_FINISH;
                end
            end
            bmbr_pkg::BMBR_FINISH: begin
                // a withdrawn request never parks the bus
                if (!hold_req_i) begin
                    st_nxt = bmbr_pkg::BMBR_RUN;
                end else if (cycle_end_i) begin
                    st_nxt = bmbr_pkg::BMBR_HOLD;
                end
            end
            bmbr_pkg::BMBR_HOLD: begin
                if (!hold_req_i) begin
                    st_nxt = bmbr_pkg::BMBR_RUN;
                end
            end
            default: st_nxt = bmbr_pkg::BMBR_RUN;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= bmbr_pkg::BMBR_RUN;
        end else begin
            st_r <= st_nxt;
        end
    end

    // acknowledge follows the request only
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hlda_r <= `BMBR_HLDA_RST;
        end else begin
            hlda_r <= hold_req_i && (st_nxt != bmbr_pkg::BMBR_RUN);
        end
    end

    // hold flag kept beside the state so the pin needs no decode
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            in_hold_r <= `BMBR_HOLD_RST;
        end else begin
            in_hold_r <= (st_nxt == bmbr_pkg::BMBR_HOLD);
        end
    end

    // ready pass-through, registered; slow cards pull it low
    // the copy costs one clock, so a card must pull early enough
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdy_r <= `BMBR_RDY_RST;
        end else begin
            rdy_r <= ext_rdy_i;
        end
    end

    // ------------------------------------------------------------
    // core values
    // ------------------------------------------------------------
    // every core value pin leaves a flip-flop; the price is one clock between
    // the core and the bus lines
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            stat_q_r <= `BMBR_STAT_RST;
            cc_q_r <= `BMBR_CC_RST;
            addr_q_r <= `BMBR_ADDR_RST;
            dout_q_r <= `BMBR_DATA_RST;
        end else begin
            stat_q_r <= stat_q_i;
            cc_q_r <= cc_q_i;
            addr_q_r <= addr_q_i;
            dout_q_r <= dout_q_i;
        end
    end

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    // flags and ready go out straight from their registers
    assign hlda_o = hlda_r;
    assign cpu_rdy_o = rdy_r;
    assign in_hold_o = in_hold_r;
    // own the address and data bus unless parked in hold
    assign bus_own = (st_r != bmbr_pkg::BMBR_HOLD);

    // ------------------------------------------------------------
    // buffer groups
    // ------------------------------------------------------------
    // enables are combinational: an outside master must win at once
    // status and control follow reset only; address and data give way
    bmbr_buf_group #(.W(`BMBR_STAT_W)) u_stat (
        .core_q_i(stat_q_r),
        .core_en_i(rst_n),
        .dsb_i(stat_dsb_i),
        .bus_q_o(stat_o),
        .bus_oe_o(stat_oe_o)
    );

    bmbr_buf_group #(.W(`BMBR_CC_W)) u_cc (
        .core_q_i(cc_q_r),
        .core_en_i(rst_n),
        .dsb_i(cc_dsb_i),
        .bus_q_o(cc_o),
        .bus_oe_o(cc_oe_o)
    );

    bmbr_buf_group #(.W(`BMBR_ADDR_W)) u_addr (
        .core_q_i(addr_q_r),
        .core_en_i(rst_n & bus_own),
        .dsb_i(addr_dsb_i),
        .bus_q_o(addr_o),
        .bus_oe_o(addr_oe_o)
    );

    bmbr_buf_group #(.W(`BMBR_DATA_W)) u_dout (
        .core_q_i(dout_q_r),
        .core_en_i(rst_n & bus_own & dout_en_i),
        .dsb_i(dout_dsb_i),
        .bus_q_o(dout_o),
        .bus_oe_o(dout_oe_o)
    );

endmodule

// ==== testbench.sv ====
`timescale 1ns/1ns

// ----------------------------------------
// bench top
// ----------------------------------------
module testbench;
    logic clk = 0, rst_n = 0, want = 0, slow = 0, ce = 0, hreq, erdy;
    logic hlda, rdy, inh;
    logic [3:0] dsb = '0;
    logic [1:0] ign = '0;
    logic [7:0] so, soe, dq, doe;
    logic [5:0] co, coe;
    logic [15:0] ao, aoe;
    logic [37:0] msk [4] = '{38'h3fc0000000, 38'h3f000000, 38'hffff00, 38'hff};
    int errors = 0, check_count = 0;
    always #4 clk = ~clk;
    bmbr_peer peer (.ref_clk_i(clk), .want_i(want), .slow_i(slow),
        .hold_req_o(hreq), .ext_rdy_o(erdy));
    bmbr_top uut (.ref_clk_i(clk), .rst_n_i(rst_n), .stat_q_i(8'ha5),
        .cc_q_i(6'h2a), .addr_q_i(16'hc35a), .dout_q_i(8'h3c),
        .dout_en_i(1'b1), .cycle_end_i(ce), .stat_dsb_i(dsb[0]),
        .cc_dsb_i(dsb[1]), .addr_dsb_i(dsb[2]), .dout_dsb_i(dsb[3]),
        .hold_req_i(hreq), .ext_rdy_i(erdy), .unprot_i(ign[0]),
        .single_step_i(ign[1]), .stat_o(so), .stat_oe_o(soe), .cc_o(co),
        .cc_oe_o(coe), .addr_o(ao), .addr_oe_o(aoe), .dout_o(dq),
        .dout_oe_o(doe), .hlda_o(hlda), .cpu_rdy_o(rdy), .in_hold_o(inh));
    task chk(input logic [47:0] s, input logic [47:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task close_out;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // each disable alone, looked at before and after an edge passes
    task t_dsb;
        for (int i = 0; i < 4; i++) begin
            dsb = 4'h1 << i;
            #1 chk({soe, coe, aoe, doe}, 38'(~msk[i]));
            step(1);
            chk({soe, coe, aoe, doe}, 38'(~msk[i]));
        end
        dsb = '0;
        step(1);
    endtask
    // no request: ack must stay low over cycle ends
    task t_hold;
        ce = 1;
        step(3);
        chk(hlda, 1'b0);
        ce = 0;
        want = 1;
        step(2);
        chk({hlda, inh}, 2'h2);
        ce = 1;
        step(1);
        ce = 0;
        chk({inh, aoe, doe}, 25'h1000000);
        want = 0;
        step(2);
        chk({hlda, inh, aoe}, 18'hffff);
        // request withdrawn before the cycle ends: the bus stays ours
        want = 1;
        step(2);
        want = 0;
        step(2);
        ce = 1;
        step(1);
        ce = 0;
        chk({hlda, inh, aoe}, 18'hffff);
    endtask
    // ignored lines must not disturb the drivers
    task t_ign;
        for (int i = 0; i < 4; i++) begin
            ign = i[1:0];
            step(1);
            chk({soe, coe, aoe, doe, hlda}, 39'h7ffffffffe);
            chk({so, co, ao, dq}, {8'ha5, 6'h2a, 16'hc35a, 8'h3c});
        end
    endtask
    // reset in mid-run: every driver lets go at once, then returns
    task t_rst;
        rst_n = 0;
        #1 chk({soe, coe, aoe, doe, hlda, rdy, inh}, 41'h0);
        step(4);
        rst_n = 1;
        step(3);
        chk({soe, coe, aoe, doe, hlda}, 39'h7ffffffffe);
    endtask
    // slow card stretches the cycle through ready
    task t_rdy;
        slow = 1;
        step(3);
        chk(rdy, 1'b0);
        slow = 0;
        step(3);
        chk(rdy, 1'b1);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1;
        step(4);
        t_dsb;
        t_hold;
        t_ign;
        t_rst;
        t_rdy;
        close_out;
    end
endmodule
